// >>> design/mpu_pkg.sv
// Constants, field layouts and types shared by the region permission checker.
// Assumes a single clock domain and a plain register port of byte addresses.
// Summary of operation
// [R1] Region attribute fields govern accesses hitting it.
// [R2] Disallowed access faults instead of completing.
// [R3] Code 000 denies all; 001 privileged only.
// [R4] Code 010 faults unprivileged writes; 011 full.
// [R5] Code 101 allows privileged reads only.
// [R6] Codes 110/111 read-only; code 100 reserved.
// [R7] Type extension 000/010 decode to memory types.
// [R8] Shareable flag ignored for ordered/device/reserved.
// [R9] Type extension top bit: normal, outer/inner policies.
// [R10] Two-bit cache policy code meanings.
// [R11] Cache and share bits stored, never act.
// [R12] Software should use recommended attribute settings.
// [R13] Violation signals memory management fault exception.
// [R14] Violation cause recorded in readable status register.
// [R15] Highest-numbered matching region wins.
// [R16] Background region is privileged-only, default attributes.
// [R17] Subregion disable bits exclude part of region.
// [R18] No-execute flag faults instruction fetches.
package mpu_pkg;

  localparam int NUM_RGN = 8;
  localparam int RGN_IDX_W = 3;
  localparam int REG_ADDR_W = 8;

  // Register byte offsets.
  localparam logic [REG_ADDR_W-1:0] OFS_CONTROL = 8'h00;
  localparam logic [REG_ADDR_W-1:0] OFS_REGION_NUMBER = 8'h04;
  localparam logic [REG_ADDR_W-1:0] OFS_REGION_BASE = 8'h08;
  localparam logic [REG_ADDR_W-1:0] OFS_REGION_ATTRIBUTE_REGISTER = 8'h0c;
  localparam logic [REG_ADDR_W-1:0] OFS_MEMORY_FAULT_STATUS_REGISTER = 8'h10;
  localparam logic [REG_ADDR_W-1:0] OFS_FAULT_ADDRESS = 8'h14;
  localparam logic [REG_ADDR_W-1:0] OFS_FAULT_MASK = 8'h18;

  // Field positions in the control, base and attribute words.
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int BASE_LSB = 5;
  localparam int ATTR_NOEXEC_BIT = 28;
  localparam int ATTR_PERM_LSB = 24;
  localparam int ATTR_TYPEX_LSB = 19;
  localparam int ATTR_SHARE_BIT = 18;
  localparam int ATTR_CACHE_BIT = 17;
  localparam int ATTR_BUFF_BIT = 16;
  localparam int ATTR_SUBDIS_LSB = 8;
  localparam int ATTR_SIZE_LSB = 1;
  localparam int ATTR_EN_BIT = 0;

  // Size code n gives a region of 2^(n+1) bytes; 7 is 256 bytes.
  localparam logic [4:0] SIZE_MIN = 5'h04;
  localparam logic [4:0] SIZE_SUB_MIN = 5'h07;
  localparam logic [5:0] SUB_IDX_DROP = 6'h02;

  // Fault status bits.
  localparam int STAT_W = 3;
  localparam int STAT_FETCH = 0;
  localparam int STAT_DATA = 1;
  localparam int STAT_BACKGROUND = 2;

  // Access permission codes.
  localparam logic [2:0] PERM_NONE = 3'h0;
  localparam logic [2:0] PERM_PRIV = 3'h1;
  localparam logic [2:0] PERM_USER_RO = 3'h2;
  localparam logic [2:0] PERM_FULL = 3'h3;
  localparam logic [2:0] PERM_RSVD = 3'h4;
  localparam logic [2:0] PERM_PRIV_RO = 3'h5;
  localparam logic [2:0] PERM_RO = 3'h6;
  localparam logic [2:0] PERM_RO_ALT = 3'h7;

  // Type extension codes without the top bit.
  localparam logic [2:0] TYPX_BASIC = 3'h0;
  localparam logic [2:0] TYPX_PLAIN = 3'h1;
  localparam logic [2:0] TYPX_DEVICE = 3'h2;

  // Cache policy codes.
  localparam logic [1:0] POL_NONCACHE = 2'h0;
  localparam logic [1:0] POL_WB_ALLOC = 2'h1;
  localparam logic [1:0] POL_WT = 2'h2;
  localparam logic [1:0] POL_WB = 2'h3;

  typedef enum logic [1:0] {
    MT_STRONG = 2'h0,
    MT_DEVICE = 2'h1,
    MT_NORMAL = 2'h3,
    MT_RESERVED = 2'h2
  } mem_type_t;

  typedef struct packed {
    logic [31-BASE_LSB:0] base;
    logic no_execute_flag;
    logic [2:0] access_permission_field;
    logic [2:0] type_extension_field;
    logic share;
    logic cache;
    logic buff;
    logic [7:0] subregion_disable_mask;
    logic [4:0] size;
    logic en;
  } region_t;

  // Background: privileged read/write, normal write-through memory.
  localparam region_t BG_REGION = '{base: '0, no_execute_flag: 1'b0,
    access_permission_field: PERM_PRIV, type_extension_field: TYPX_BASIC,
    share: 1'b0, cache: 1'b1, buff: 1'b0, subregion_disable_mask: 8'h00,
    size: 5'h1f, en: 1'b1};

endpackage : mpu_pkg

// >>> design/attr_decode.sv
// Attribute decoder and permission check for one selected region.
// Purely combinational; the caller registers the results.
`timescale 1ns/1ps
module attr_decode
  import mpu_pkg::*;
(
  input wire logic [2:0] type_ext_i, // Type extension field.
  input wire logic share_i, // Shareable flag.
  input wire logic cache_i, // Cacheable flag.
  input wire logic buff_i, // Bufferable flag.
  input wire logic [2:0] perm_i, // Access permission field.
  input wire logic no_exec_i, // No-execute flag.
  input wire logic priv_i, // Access is privileged.
  input wire logic write_i, // Access is a write.
  input wire logic fetch_i, // Access is an instruction fetch.
  output mpu_pkg::mem_type_t mem_type_o, // Decoded memory type.
  output logic shareable_o, // Decoded shareability.
  output logic [1:0] outer_pol_o, // Outer cache policy.
  output logic [1:0] inner_pol_o, // Inner cache policy.
  output logic allow_o // Access is permitted.
);

  // Memory type and policy decode; these outputs only export attributes.
  always_comb begin
    mem_type_o = MT_RESERVED;
    shareable_o = 1'b0;
    outer_pol_o = POL_NONCACHE;
    inner_pol_o = POL_NONCACHE;
    // [R9] Cached normal memory.
    if (type_ext_i[2]) begin
      mem_type_o = MT_NORMAL;
      shareable_o = share_i;
      // [R10] Policy code pass-through.
      outer_pol_o = type_ext_i[1:0];
      inner_pol_o = {cache_i, buff_i};
    end else begin
      unique case (type_ext_i)
        // [R7] Basic type decode.
        TYPX_BASIC: begin
          if (cache_i) begin
            mem_type_o = MT_NORMAL;
            shareable_o = share_i;
            outer_pol_o = buff_i ? POL_WB : POL_WT;
            inner_pol_o = buff_i ? POL_WB : POL_WT;
          end else begin
            // [R8] Shareable flag ignored.
            mem_type_o = buff_i ? MT_DEVICE : MT_STRONG;
            shareable_o = 1'b1;
          end
        end
        TYPX_PLAIN: begin
          if (cache_i == buff_i) begin
            mem_type_o = MT_NORMAL;
            shareable_o = share_i;
            outer_pol_o = cache_i ? POL_WB_ALLOC : POL_NONCACHE;
            inner_pol_o = cache_i ? POL_WB_ALLOC : POL_NONCACHE;
          end
        end
        // [R7] Nonshared device decode.
        TYPX_DEVICE: begin
          if (!cache_i && !buff_i) begin
            mem_type_o = MT_DEVICE;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Permission decode. The reserved code is refused outright, the safest reading.
  always_comb begin
    allow_o = 1'b0;
    unique case (perm_i)
      // [R3] No access and privileged only.
      PERM_NONE: allow_o = 1'b0;
      PERM_PRIV: allow_o = priv_i;
      // [R4] User read-only and full access.
      PERM_USER_RO: allow_o = priv_i || !write_i;
      PERM_FULL: allow_o = 1'b1;
      // [R6] Reserved code faults.
      PERM_RSVD: allow_o = 1'b0;
      // [R5] Privileged read only.
      PERM_PRIV_RO: allow_o = priv_i && !write_i;
      // [R6] Read-only for everybody.
      PERM_RO, PERM_RO_ALT: allow_o = !write_i;
    endcase
    // [R18] Fetch from no-execute region.
    if (no_exec_i && fetch_i) begin
      allow_o = 1'b0;
    end
  end

endmodule : attr_decode

// >>> design/mpu_attr_check.sv
// Region lookup, permission checking and fault reporting for the core's accesses.
// Assumes the access request comes from logic on clock_i and the register
// master follows the one-cycle strobe protocol with read data one cycle later.
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module mpu_attr_check (
  input wire logic clock_i, // System clock, 40 MHz.
  input wire logic srst_i, // Synchronous reset, active high.
  input wire logic [mpu_pkg::REG_ADDR_W-1:0] reg_addr_i, // Register byte address.
  input wire logic [31:0] reg_wdata_i, // Register write data.
  input wire logic reg_wr_i, // Register write strobe.
  input wire logic reg_rd_i, // Register read strobe.
  output logic [31:0] reg_rdata_o, // Read data, cycle after the strobe.
  input wire logic acc_valid_i, // Access request valid.
  input wire logic [31:0] acc_addr_i, // Access address.
  input wire logic acc_write_i, // Access is a write.
  input wire logic acc_priv_i, // Access is privileged.
  input wire logic acc_fetch_i, // Access is an instruction fetch.
  output logic acc_done_o, // Check result valid, one cycle pulse.
  output logic acc_fault_o, // Permission fault, one cycle pulse.
  output mpu_pkg::mem_type_t acc_mem_type_o, // Memory type of the access.
  output logic acc_shareable_o, // Shareability of the access.
  output logic [1:0] acc_outer_pol_o, // Outer cache policy.
  output logic [1:0] acc_inner_pol_o, // Inner cache policy.
  output logic irq_o // Memory fault interrupt, level.
);
  import mpu_pkg::*;

  typedef struct packed {
    logic enable;
    logic [RGN_IDX_W-1:0] number;
    region_t [NUM_RGN-1:0] rgn;
    logic [STAT_W-1:0] stat;
    logic [STAT_W-1:0] mask;
    logic [31:0] fault_addr;
    logic [31:0] rdata;
    logic done;
    logic fault;
    mem_type_t mem_type;
    logic share;
    logic [1:0] outer_pol;
    logic [1:0] inner_pol;
  } state_t;

  state_t cur_q;
  state_t nxt_d;

  logic [RGN_IDX_W:0] lookup;
  logic win_hit;
  logic [RGN_IDX_W-1:0] win_idx;
  region_t win;
  region_t sel;
  mem_type_t dec_type;
  logic dec_share;
  logic [1:0] dec_outer;
  logic [1:0] dec_inner;
  logic dec_allow;
  logic chk_fault;
  logic [STAT_W-1:0] stat_set;

  // Region match with optional subregion exclusion.
  function automatic logic rgn_hit(region_t r, logic [31:0] a);
    logic [31:0] m;
    logic [2:0] sub;
    logic hit;
    m = 32'hffffffff << ({1'b0, r.size} + 6'h01);
    hit = r.en && (r.size >= SIZE_MIN) && (((a ^ {r.base, 5'h00}) & m) == 32'h00000000);
    sub = 3'((a >> ({1'b0, r.size} - SUB_IDX_DROP)) & 32'h00000007);
    // [R17] Disabled subregion drops out.
    if (r.size >= SIZE_SUB_MIN && r.subregion_disable_mask[sub]) begin
      hit = 1'b0;
    end
    return hit;
  endfunction : rgn_hit

  // Scan upward so that a later hit overrides an earlier one.
  function automatic logic [RGN_IDX_W:0] win_lookup(region_t [NUM_RGN-1:0] r,
                                                    logic [31:0] a);
    logic [RGN_IDX_W:0] res;
    res = '0;
    for (int i = 0; i < NUM_RGN; i++) begin
      // [R15] Highest number wins.
      if (rgn_hit(r[i], a)) begin
        res = {1'b1, RGN_IDX_W'(i)};
      end
    end
    return res;
  endfunction : win_lookup

  // Winning region, or the background when nothing matches.
  assign lookup = win_lookup(cur_q.rgn, acc_addr_i);
  assign win_hit = lookup[RGN_IDX_W];
  assign win_idx = lookup[RGN_IDX_W-1:0];
  assign win = cur_q.rgn[win_idx];
  // [R16] Background attributes apply.
  assign sel = win_hit ? win : BG_REGION;

  // [R1] Selected region attributes decoded.
  attr_decode u_decode (
    .type_ext_i(sel.type_extension_field),
    .share_i(sel.share),
    .cache_i(sel.cache),
    .buff_i(sel.buff),
    .perm_i(sel.access_permission_field),
    .no_exec_i(sel.no_execute_flag),
    .priv_i(acc_priv_i),
    .write_i(acc_write_i),
    .fetch_i(acc_fetch_i),
    .mem_type_o(dec_type),
    .shareable_o(dec_share),
    .outer_pol_o(dec_outer),
    .inner_pol_o(dec_inner),
    .allow_o(dec_allow)
  );

  // A disabled unit lets every access through unchecked.
  // [R2] Refused access faults.
  assign chk_fault = acc_valid_i && cur_q.enable && !dec_allow;

  // Fault cause bits for this access.
  // [R14] Cause of the fault.
  always_comb begin
    stat_set = '0;
    if (chk_fault) begin
      stat_set[STAT_FETCH] = acc_fetch_i;
      stat_set[STAT_DATA] = !acc_fetch_i;
      stat_set[STAT_BACKGROUND] = !win_hit;
    end
  end

  // Next-state logic for the whole block.
  always_comb begin
    nxt_d = cur_q;
    nxt_d.rdata = 32'h00000000;
    nxt_d.done = acc_valid_i;
    nxt_d.fault = chk_fault;
    // [R11] Attributes exported only, never acted on.
    if (acc_valid_i) begin
      nxt_d.mem_type = dec_type;
      nxt_d.share = dec_share;
      nxt_d.outer_pol = dec_outer;
      nxt_d.inner_pol = dec_inner;
    end
    if (chk_fault) begin
      nxt_d.fault_addr = acc_addr_i;
    end
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        OFS_CONTROL: nxt_d.enable = reg_wdata_i[CTRL_ENABLE_BIT];
        OFS_REGION_NUMBER: nxt_d.number = reg_wdata_i[RGN_IDX_W-1:0];
        OFS_REGION_BASE: nxt_d.rgn[cur_q.number].base = reg_wdata_i[31:BASE_LSB];
        // [R1] Attribute fields stored.
        OFS_REGION_ATTRIBUTE_REGISTER: begin
          nxt_d.rgn[cur_q.number].no_execute_flag = reg_wdata_i[ATTR_NOEXEC_BIT];
          nxt_d.rgn[cur_q.number].access_permission_field =
            reg_wdata_i[ATTR_PERM_LSB +: 3];
          nxt_d.rgn[cur_q.number].type_extension_field = reg_wdata_i[ATTR_TYPEX_LSB +: 3];
          nxt_d.rgn[cur_q.number].share = reg_wdata_i[ATTR_SHARE_BIT];
          nxt_d.rgn[cur_q.number].cache = reg_wdata_i[ATTR_CACHE_BIT];
          nxt_d.rgn[cur_q.number].buff = reg_wdata_i[ATTR_BUFF_BIT];
          nxt_d.rgn[cur_q.number].subregion_disable_mask =
            reg_wdata_i[ATTR_SUBDIS_LSB +: 8];
          nxt_d.rgn[cur_q.number].size = reg_wdata_i[ATTR_SIZE_LSB +: 5];
          nxt_d.rgn[cur_q.number].en = reg_wdata_i[ATTR_EN_BIT];
        end
        OFS_MEMORY_FAULT_STATUS_REGISTER: nxt_d.stat = cur_q.stat & ~reg_wdata_i[STAT_W-1:0];
        OFS_FAULT_MASK: nxt_d.mask = reg_wdata_i[STAT_W-1:0];
        default: begin
        end
      endcase
    end
    // [R14] New fault beats a clear.
    nxt_d.stat = nxt_d.stat | stat_set;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        OFS_CONTROL: nxt_d.rdata[CTRL_ENABLE_BIT] = cur_q.enable;
        OFS_REGION_NUMBER: nxt_d.rdata[RGN_IDX_W-1:0] = cur_q.number;
        OFS_REGION_BASE: nxt_d.rdata[31:BASE_LSB] = cur_q.rgn[cur_q.number].base;
        OFS_REGION_ATTRIBUTE_REGISTER: begin
          nxt_d.rdata[ATTR_NOEXEC_BIT] = cur_q.rgn[cur_q.number].no_execute_flag;
          nxt_d.rdata[ATTR_PERM_LSB +: 3] = cur_q.rgn[cur_q.number].access_permission_field;
          nxt_d.rdata[ATTR_TYPEX_LSB +: 3] = cur_q.rgn[cur_q.number].type_extension_field;
          nxt_d.rdata[ATTR_SHARE_BIT] = cur_q.rgn[cur_q.number].share;
          nxt_d.rdata[ATTR_CACHE_BIT] = cur_q.rgn[cur_q.number].cache;
          nxt_d.rdata[ATTR_BUFF_BIT] = cur_q.rgn[cur_q.number].buff;
          nxt_d.rdata[ATTR_SUBDIS_LSB +: 8] = cur_q.rgn[cur_q.number].subregion_disable_mask;
          nxt_d.rdata[ATTR_SIZE_LSB +: 5] = cur_q.rgn[cur_q.number].size;
          nxt_d.rdata[ATTR_EN_BIT] = cur_q.rgn[cur_q.number].en;
        end
        OFS_MEMORY_FAULT_STATUS_REGISTER: nxt_d.rdata[STAT_W-1:0] = cur_q.stat;
        OFS_FAULT_ADDRESS: nxt_d.rdata = cur_q.fault_addr;
        OFS_FAULT_MASK: nxt_d.rdata[STAT_W-1:0] = cur_q.mask;
        default: nxt_d.rdata = 32'h00000000;
      endcase
    end
  end

  // State register; every field resets to zero, which is strongly ordered.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cur_q <= '0;
    end else begin
      cur_q <= nxt_d;
    end
  end

  // Outputs straight from the state register.
  assign reg_rdata_o = cur_q.rdata;
  assign acc_done_o = cur_q.done;
  // [R13] Fault pulse to the core.
  assign acc_fault_o = cur_q.fault;
  assign acc_mem_type_o = cur_q.mem_type;
  assign acc_shareable_o = cur_q.share;
  assign acc_outer_pol_o = cur_q.outer_pol;
  assign acc_inner_pol_o = cur_q.inner_pol;
  // [R13] Masked status raises the interrupt.
  assign irq_o = |(cur_q.stat & cur_q.mask);

  default clocking dcb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);

  // A disabled unit never refuses an access.
  AST_DISABLED_PASS: assert property ( // [R2]
    acc_valid_i && !cur_q.enable |=> acc_done_o && !acc_fault_o)
    else $error("Access faulted while the unit was disabled.");

  // Code 000 in a matching region refuses privileged reads too.
  AST_PERM_NONE: assert property ( // [R3]
    acc_valid_i && cur_q.enable && win_hit && win.access_permission_field == PERM_NONE
    |=> acc_fault_o)
    else $error("No-access region let an access through.");

  // Code 010 faults an unprivileged write and passes an unprivileged read.
  AST_PERM_USER_RO: assert property ( // [R4]
    acc_valid_i && cur_q.enable && win_hit && !acc_fetch_i && !acc_priv_i &&
    win.access_permission_field == PERM_USER_RO |=> acc_fault_o == $past(acc_write_i))
    else $error("User read-only region checked wrongly.");

  // Code 101 passes only privileged reads.
  AST_PERM_PRIV_RO: assert property ( // [R5]
    acc_valid_i && cur_q.enable && win_hit && !win.no_execute_flag &&
    win.access_permission_field == PERM_PRIV_RO
    |=> acc_fault_o == !($past(acc_priv_i) && !$past(acc_write_i)))
    else $error("Privileged read-only region checked wrongly.");

  // Read-only codes fault every write.
  AST_PERM_RO_WRITE: assert property ( // [R6]
    acc_valid_i && cur_q.enable && win_hit && acc_write_i &&
    win.access_permission_field[2:1] == 2'b11 |=> acc_fault_o)
    else $error("Write to read-only region was not refused.");

  // Plain strongly ordered encoding reaches the type output.
  AST_TYPE_STRONG: assert property ( // [R7]
    acc_valid_i && win_hit && win.type_extension_field == TYPX_BASIC &&
    !win.cache && !win.buff |=> acc_mem_type_o == MT_STRONG && acc_shareable_o)
    else $error("Strongly ordered encoding decoded wrongly.");

  // Top type extension bit exports the outer policy from the low bits.
  AST_TYPE_CACHED: assert property ( // [R9]
    acc_valid_i && win_hit && win.type_extension_field[2]
    |=> acc_mem_type_o == MT_NORMAL &&
        acc_outer_pol_o == $past(win.type_extension_field[1:0]))
    else $error("Cached normal encoding decoded wrongly.");

  // Unprivileged access outside every region faults and marks the background.
  AST_BACKGROUND: assert property ( // [R16]
    acc_valid_i && cur_q.enable && !win_hit && !acc_priv_i
    |=> acc_fault_o && cur_q.stat[STAT_BACKGROUND])
    else $error("Unprivileged background access was not refused.");

  // A fetch from a no-execute region faults whatever the permission code.
  AST_NOEXEC_FETCH: assert property ( // [R18]
    acc_valid_i && cur_q.enable && win_hit && win.no_execute_flag && acc_fetch_i
    |=> acc_fault_o && cur_q.stat[STAT_FETCH])
    else $error("Fetch from no-execute region was not refused.");

  // A fault records its address and, with all causes unmasked, raises the interrupt.
  AST_FAULT_RECORD: assert property ( // [R14]
    acc_fault_o && cur_q.mask == '1 |-> irq_o && cur_q.fault_addr == $past(acc_addr_i))
    else $error("Fault not recorded or interrupt not raised.");

  // An idle cycle gives neither answer nor fault.
  AST_DONE_IDLE: assert property ( // [R13]
    !acc_valid_i
    |=> !acc_done_o && !acc_fault_o)
    else $error("Answer without a request.");

  // Every request is answered in the next cycle, so the core never stalls.
  AST_DONE_ANSWER: assert property ( // [R2]
    acc_valid_i |=> acc_done_o)
    else $error("Request left unanswered.");

  // Code 001 passes privileged accesses only.
  AST_PERM_PRIV: assert property ( // [R3]
    acc_valid_i && cur_q.enable && win_hit && !win.no_execute_flag &&
    win.access_permission_field == PERM_PRIV |=> acc_fault_o == !$past(acc_priv_i))
    else $error("Privileged-only region checked wrongly.");

  // Code 011 passes everything but a no-execute fetch.
  AST_PERM_FULL: assert property ( // [R4]
    acc_valid_i && win_hit && !win.no_execute_flag &&
    win.access_permission_field == PERM_FULL |=> !acc_fault_o)
    else $error("Full-access region refused an access.");

  // The reserved code faults every access.
  AST_PERM_RSVD: assert property ( // [R6]
    acc_valid_i && cur_q.enable && win_hit &&
    win.access_permission_field == PERM_RSVD |=> acc_fault_o)
    else $error("Reserved code let an access through.");

  // Basic type extension with the cacheable flag is normal memory.
  AST_TYPE_NORMAL: assert property ( // [R7]
    acc_valid_i && win_hit && win.type_extension_field == TYPX_BASIC && win.cache
    |=> acc_mem_type_o == MT_NORMAL)
    else $error("Cacheable basic encoding decoded wrongly.");

  // Basic device memory reports shareable whatever the flag says.
  AST_TYPE_DEVICE: assert property ( // [R8]
    acc_valid_i && win_hit && win.type_extension_field == TYPX_BASIC &&
    !win.cache && win.buff |=> acc_mem_type_o == MT_DEVICE && acc_shareable_o)
    else $error("Device encoding decoded wrongly.");

  // Cached regions pass the flag pair through as the inner policy.
  AST_INNER_POL: assert property ( // [R10]
    acc_valid_i && win_hit && win.type_extension_field[2]
    |=> acc_inner_pol_o == $past({win.cache, win.buff}))
    else $error("Inner policy of cached region wrong.");

  // Status bits stay set until software clears them.
  AST_STAT_STICKY: assert property ( // [R14]
    !(reg_wr_i && reg_addr_i == OFS_MEMORY_FAULT_STATUS_REGISTER)
    |=> (cur_q.stat & $past(cur_q.stat)) == $past(cur_q.stat))
    else $error("Fault status bit dropped without a clear.");

endmodule : mpu_attr_check

// >>> test/core_model.sv
// Behavioural model of the core that issues checked memory accesses.
// Assumes the bench asks for one access by pulsing go_i for one cycle.
`timescale 1ns/1ps
module core_model (
  input wire logic clock_i, // Bench clock.
  input wire logic go_i, // Issue one access.
  input wire logic [31:0] addr_i, // Address to issue.
  input wire logic write_i, // Write access.
  input wire logic priv_i, // Privileged access.
  input wire logic fetch_i, // Instruction fetch.
  output logic acc_valid_o = 1'b0, // Access valid.
  output logic [31:0] acc_addr_o = '0, // Access address.
  output logic acc_write_o = 1'b0, // Access is a write.
  output logic acc_priv_o = 1'b0, // Access is privileged.
  output logic acc_fetch_o = 1'b0 // Access is a fetch.
);
  // Idle qualifiers toggle so no stale value can pass for a real request.
  always_ff @(posedge clock_i) begin
    acc_valid_o <= go_i;
    acc_addr_o <= go_i ? addr_i : ~acc_addr_o;
    acc_write_o <= go_i ? write_i : ~acc_write_o;
    acc_priv_o <= go_i ? priv_i : ~acc_priv_o;
    acc_fetch_o <= go_i ? fetch_i : ~acc_fetch_o;
  end
endmodule : core_model

// >>> test/tb_top.sv
// Self-checking bench for the region permission checker.
// Assumes the core model drives the access port and tasks drive registers.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
  import mpu_pkg::*;
  logic clock = 1'b0, srst = 1'b1, r_wr = 1'b0, r_rd = 1'b0, go = 1'b0;
  logic [7:0] r_addr = '0;
  logic [31:0] r_wdata = '0, g_addr = '0, a_addr, r_rdata;
  logic g_write = 1'b0, g_priv = 1'b0, g_fetch = 1'b0;
  logic a_valid, a_write, a_priv, a_fetch, done, fault, shr, irq;
  logic [1:0] opol, ipol;
  mem_type_t mtype;
  int fails = 0, check_count = 0, seed = 1;

  // Clock of 25 ns.
  always #12.5 clock = ~clock;

  core_model i_core (.clock_i(clock), .go_i(go), .addr_i(g_addr), .write_i(g_write),
    .priv_i(g_priv), .fetch_i(g_fetch), .acc_valid_o(a_valid), .acc_addr_o(a_addr),
    .acc_write_o(a_write), .acc_priv_o(a_priv), .acc_fetch_o(a_fetch));

  mpu_attr_check i_dut (.clock_i(clock), .srst_i(srst), .reg_addr_i(r_addr),
    .reg_wdata_i(r_wdata), .reg_wr_i(r_wr), .reg_rd_i(r_rd), .reg_rdata_o(r_rdata),
    .acc_valid_i(a_valid), .acc_addr_i(a_addr), .acc_write_i(a_write),
    .acc_priv_i(a_priv), .acc_fetch_i(a_fetch), .acc_done_o(done), .acc_fault_o(fault),
    .acc_mem_type_o(mtype), .acc_shareable_o(shr), .acc_outer_pol_o(opol),
    .acc_inner_pol_o(ipol), .irq_o(irq));

  // Prints the verdict and ends the run.
  task automatic print_verdict();
    if (fails == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict

  // One-cycle register write.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    r_addr <= a;
    r_wdata <= d;
    r_wr <= 1'b1;
    @(posedge clock);
    r_wr <= 1'b0;
  endtask : wr

  // Register read; data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    r_addr <= a;
    r_rd <= 1'b1;
    @(posedge clock);
    r_rd <= 1'b0;
    #1 `CHK(r_rdata, e)
  endtask : rd

  // One access through the core model, with a bounded wait for the answer.
  task automatic acc(input logic [31:0] a, input logic w, p, f, e);
    int n;
    @(posedge clock);
    g_addr <= a;
    g_write <= w;
    g_priv <= p;
    g_fetch <= f;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 4) begin
      @(posedge clock);
      #1 n++;
    end
    if (n == 4) begin
      fails++;
      $display("CHECK FAILED %0t access not answered", $time);
      print_verdict();
    end else `CHK(fault, e)
  endtask : acc

  // Expected permission outcome; the reserved code is taken as no access.
  function automatic logic allow(logic [2:0] p, logic pr, logic w);
    case (p)
      PERM_NONE: return 1'b0;
      PERM_PRIV: return pr;
      PERM_USER_RO: return pr | !w;
      PERM_FULL: return 1'b1;
      PERM_PRIV_RO: return pr & !w;
      PERM_RO, PERM_RO_ALT: return !w;
      default: return 1'b0;
    endcase
  endfunction : allow

  // Expected type, share, outer and inner policy.
  function automatic logic [6:0] attr_exp(logic [2:0] t, logic s, c, b);
    if (t[2]) return {MT_NORMAL, s, t[1:0], c, b};
    case ({t, c, b})
      5'h00: return {MT_STRONG, 1'b1, 4'h0};
      5'h01: return {MT_DEVICE, 1'b1, 4'h0};
      5'h02: return {MT_NORMAL, s, 4'ha};
      5'h03: return {MT_NORMAL, s, 4'hf};
      5'h04: return {MT_NORMAL, s, 4'h0};
      5'h07: return {MT_NORMAL, s, 4'h5};
      5'h08: return {MT_DEVICE, 1'b0, 4'h0};
      default: return {MT_RESERVED, 1'b0, 4'h0};
    endcase
  endfunction : attr_exp

  // Packs an enabled attribute word.
  function automatic logic [31:0] attr(logic x, logic [2:0] p, t, logic s, c, b,
      logic [7:0] sd, logic [4:0] sz);
    return {3'h0, x, 1'b0, p, 2'h0, t, s, c, b, sd, 2'h0, sz, 1'b1};
  endfunction : attr

  // Main sequence; random attributes prove the cache bits never gate access.
  initial begin
    logic [2:0] p, t;
    logic pr, w, s, c, b;
    logic [6:0] e;
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    rd(8'h10, 32'h0);
    rd(8'h1c, 32'h0);
    acc(32'h40, 1'b1, 1'b0, 1'b0, 1'b0);
    wr(8'h00, 32'h1);
    rd(8'h00, 32'h1);
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h0);
    wr(8'h0c, attr(1'b0, PERM_FULL, TYPX_BASIC, 1'b0, 1'b1, 1'b0, 8'h00, 5'h0b));
    for (int i = 0; i < 32; i++) begin
      p = i[4:2];
      pr = i[1];
      w = i[0];
      t = 3'($random(seed));
      {s, c, b} = 3'($random(seed));
      wr(8'h0c, attr(1'b0, p, t, s, c, b, 8'h00, 5'h0b));
      acc(32'($random(seed)) & 32'hffc, w, pr, 1'b0, !allow(p, pr, w));
      e = attr_exp(t, s, c, b);
      `CHK({mtype, shr}, e[6:4])
      `CHK({opol, ipol}, e[3:0])
    end
    wr(8'h10, 32'h7);
    rd(8'h10, 32'h0);
    wr(8'h0c, attr(1'b1, PERM_FULL, TYPX_BASIC, 1'b1, 1'b0, 1'b1, 8'h00, 5'h0b));
    acc(32'h80, 1'b0, 1'b1, 1'b1, 1'b1);
    acc(32'h84, 1'b0, 1'b1, 1'b0, 1'b0);
    `CHK({mtype, shr}, {MT_DEVICE, 1'b1})
    rd(8'h10, 32'h1);
    rd(8'h14, 32'h80);
    wr(8'h14, 32'h1234);
    rd(8'h14, 32'h80);
    #1 `CHK(irq, 1'b0)
    wr(8'h18, 32'h7);
    #1 `CHK(irq, 1'b1)
    rd(8'h18, 32'h7);
    wr(8'h10, 32'h1);
    #1 `CHK(irq, 1'b0)
    wr(8'h0c, attr(1'b0, PERM_FULL, TYPX_BASIC, 1'b0, 1'b1, 1'b0, 8'h00, 5'h0b));
    wr(8'h04, 32'h1);
    wr(8'h08, 32'h100);
    wr(8'h0c, attr(1'b0, PERM_NONE, TYPX_BASIC, 1'b0, 1'b1, 1'b0, 8'h02, 5'h07));
    acc(32'h104, 1'b0, 1'b1, 1'b0, 1'b1);
    acc(32'h124, 1'b0, 1'b1, 1'b0, 1'b0);
    acc(32'h1e0, 1'b0, 1'b1, 1'b0, 1'b1);
    acc(32'h8000, 1'b1, 1'b1, 1'b0, 1'b0);
    wr(8'h10, 32'h7);
    acc(32'h8000, 1'b0, 1'b0, 1'b0, 1'b1);
    rd(8'h10, 32'h6);
    @(posedge clock);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h18, 32'h0);
    print_verdict();
  end
endmodule : tb_top
